// ===== src/wakeup_irq_pkg.sv
package wakeup_irq_pkg;

  // event bit positions, shared by status, clear and irq enable registers
  localparam int EVT_W = 7;
  localparam int EVT_CMP1 = 0;
  localparam int EVT_CMP2 = 1;
  localparam int EVT_TMR1 = 2;
  localparam int EVT_TMR2 = 3;
  localparam int EVT_UTX = 4;
  localparam int EVT_URX = 5;
  localparam int EVT_UERR = 6;

  // comparator count and wake enable positions
  localparam int CMP_N = 2;
  localparam int WAKE_CMP1 = 0;
  localparam int WAKE_CMP2 = 1;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  // state register layout
  localparam int STATE_MODE_LSB = 0;
  localparam int STATE_GIE = 4;

  // values after reset
  localparam logic [6:0] STATUS_RST = 7'h00;
  localparam logic [6:0] IRQ_EN_RST = 7'h00;
  localparam logic [1:0] WAKE_EN_RST = 2'h0;

  // power states reported by the core sequencer
  typedef enum logic [3:0] {
    PWR_SLEEP = 4'b0001,
    PWR_IDLE = 4'b0010,
    PWR_LOWSPEED = 4'b0100,
    PWR_NORMAL = 4'b1000
  } power_state_t;

endpackage

// ===== src/change_sync.sv
`timescale 1ns/1ps
module change_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // asynchronous level in
  input wire logic asyncIn,
  // filtered level and change pulse
  output logic level,
  output logic changed
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a new level counts only once the two later stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
      changed <= 1'b0;
    end else begin
      changed <= (s2_q == s3_q) && (s3_q != level);
      if (s2_q == s3_q) begin
        level <= s3_q;
      end
    end
  end

endmodule

// ===== src/wakeup_interrupt_dispatch.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - comparator wake only: change wakes from sleep or idle, never interrupts.
// - comparator wake and irq: wakes, then vectors if globally enabled.
// - comparator irq only: no wake; in run states vectors if globally enabled.
// - comparator both enables clear: change neither wakes nor interrupts.
// - timer one irq enabled: wakes from idle not sleep; vector per global.
// - timer two irq enabled: wakes from idle not sleep; vector per global.
// - uart transmit done never wakes; vectors in run if enabled globally.
// - uart receive full never wakes; vectors in run if enabled globally.
// - uart receive error never wakes; vectors in run if enabled globally.
// - after wake, interrupt if the waking source's irq enable and global enable are set, else next instruction.
module wakeup_interrupt_dispatch #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [wakeup_irq_pkg::ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdData,
  // analog comparator outputs, asynchronous
  input wire logic [wakeup_irq_pkg::CMP_N-1:0] comparatorOut,
  // peripheral event pulses, core clock
  input wire logic timerOneEvt,
  input wire logic timerTwoEvt,
  input wire logic uartTxDoneEvt,
  input wire logic uartRxFullEvt,
  input wire logic uartRxErrorEvt,
  // core state
  input wire wakeup_irq_pkg::power_state_t powerMode,
  input wire logic globalIrqEnabled,
  // outcome to the sequencer
  output logic wakeUp,
  output logic resumeNext,
  output logic vectorReq,
  output logic irq
);

  if (DATA_W < wakeup_irq_pkg::EVT_W) begin : g_bad_width
    $error("DATA_W too narrow for the event registers");
  end

  logic [wakeup_irq_pkg::CMP_N-1:0] cmpChange;
  logic [wakeup_irq_pkg::EVT_W-1:0] evt;
  logic [wakeup_irq_pkg::EVT_W-1:0] status_q;
  logic [wakeup_irq_pkg::EVT_W-1:0] status_d;
  logic [wakeup_irq_pkg::EVT_W-1:0] irqEn_q;
  logic [wakeup_irq_pkg::CMP_N-1:0] wakeEn_q;
  logic [wakeup_irq_pkg::EVT_W-1:0] clrMask;
  logic [wakeup_irq_pkg::EVT_W-1:0] wakeSrc;
  logic sleeping;
  logic idling;
  logic running;
  logic wakeHit;
  logic vectorOnWake;
  logic [DATA_W-1:0] rdMux;

  // comparator inputs cross into the core domain
  for (genvar i = 0; i < wakeup_irq_pkg::CMP_N; i++) begin : g_cmp
    change_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(comparatorOut[i]),
      .level(),
      .changed(cmpChange[i])
    );
  end

  always_comb begin
    evt = '0;
    evt[wakeup_irq_pkg::EVT_CMP1] = cmpChange[0];
    evt[wakeup_irq_pkg::EVT_CMP2] = cmpChange[1];
    evt[wakeup_irq_pkg::EVT_TMR1] = timerOneEvt;
    evt[wakeup_irq_pkg::EVT_TMR2] = timerTwoEvt;
    evt[wakeup_irq_pkg::EVT_UTX] = uartTxDoneEvt;
    evt[wakeup_irq_pkg::EVT_URX] = uartRxFullEvt;
    evt[wakeup_irq_pkg::EVT_UERR] = uartRxErrorEvt;
  end

  // illegal mode codes are treated as running so nothing stays asleep
  always_comb begin
    sleeping = 1'b0;
    idling = 1'b0;
    running = 1'b0;
    unique case (powerMode)
      wakeup_irq_pkg::PWR_SLEEP: begin
        sleeping = 1'b1;
      end
      wakeup_irq_pkg::PWR_IDLE: begin
        idling = 1'b1;
      end
      wakeup_irq_pkg::PWR_LOWSPEED, wakeup_irq_pkg::PWR_NORMAL: begin
        running = 1'b1;
      end
      default: begin
        running = 1'b1;
      end
    endcase
  end

  // sources that may wake in the present power state
  always_comb begin
    wakeSrc = '0;
    if (sleeping || idling) begin
      wakeSrc[wakeup_irq_pkg::EVT_CMP1] =
        evt[wakeup_irq_pkg::EVT_CMP1] & wakeEn_q[wakeup_irq_pkg::WAKE_CMP1];
      wakeSrc[wakeup_irq_pkg::EVT_CMP2] =
        evt[wakeup_irq_pkg::EVT_CMP2] & wakeEn_q[wakeup_irq_pkg::WAKE_CMP2];
    end
    // timers run only in idle, so they cannot wake from sleep
    if (idling) begin
      wakeSrc[wakeup_irq_pkg::EVT_TMR1] =
        evt[wakeup_irq_pkg::EVT_TMR1] & irqEn_q[wakeup_irq_pkg::EVT_TMR1];
      wakeSrc[wakeup_irq_pkg::EVT_TMR2] =
        evt[wakeup_irq_pkg::EVT_TMR2] & irqEn_q[wakeup_irq_pkg::EVT_TMR2];
    end
    // uart sources have no wake path at all
  end

  assign wakeHit = |wakeSrc;
  assign vectorOnWake = globalIrqEnabled && |(wakeSrc & irqEn_q);

  // clear register: write ones to clear
  always_comb begin
    clrMask = '0;
    if (regWr && regAddr == wakeup_irq_pkg::ADDR_CLEAR) begin
      clrMask = regWrData[wakeup_irq_pkg::EVT_W-1:0];
    end
  end

  // a set in the same cycle as its clear wins
  assign status_d = (status_q & ~clrMask) | evt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_q <= wakeup_irq_pkg::STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqEn_q <= wakeup_irq_pkg::IRQ_EN_RST;
    end else if (regWr && regAddr == wakeup_irq_pkg::ADDR_IRQ_EN) begin
      irqEn_q <= regWrData[wakeup_irq_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wakeEn_q <= wakeup_irq_pkg::WAKE_EN_RST;
    end else if (regWr && regAddr == wakeup_irq_pkg::ADDR_WAKE_EN) begin
      wakeEn_q <= regWrData[wakeup_irq_pkg::CMP_N-1:0];
    end
  end

  // wake outcome: one pulse, with exactly one of vector or resume
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wakeUp <= 1'b0;
      resumeNext <= 1'b0;
    end else begin
      wakeUp <= wakeHit;
      resumeNext <= wakeHit && !vectorOnWake;
    end
  end

  // vector only with a pending enabled source and global enable;
  // in sleep or idle it waits for a wake so masked sources stay quiet
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vectorReq <= 1'b0;
    end else begin
      vectorReq <= globalIrqEnabled && (running || vectorOnWake)
                   && |(status_d & irqEn_q);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & irqEn_q);
    end
  end

  // read data; unmapped addresses and the clear register read zero
  always_comb begin
    rdMux = '0;
    unique case (regAddr)
      wakeup_irq_pkg::ADDR_STATUS: begin
        rdMux[wakeup_irq_pkg::EVT_W-1:0] = status_q;
      end
      wakeup_irq_pkg::ADDR_IRQ_EN: begin
        rdMux[wakeup_irq_pkg::EVT_W-1:0] = irqEn_q;
      end
      wakeup_irq_pkg::ADDR_WAKE_EN: begin
        rdMux[wakeup_irq_pkg::CMP_N-1:0] = wakeEn_q;
      end
      wakeup_irq_pkg::ADDR_STATE: begin
        rdMux[wakeup_irq_pkg::STATE_MODE_LSB +: 4] = powerMode;
        rdMux[wakeup_irq_pkg::STATE_GIE] = globalIrqEnabled;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= '0;
    end
  end

  a_pending_set: assert property (
    @(posedge core_clk) disable iff (rst)
    (evt != '0) |=> ((status_q & $past(evt)) == $past(evt))
  ) else $error("event did not set its pending flag");

  a_pending_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    (clrMask == '0) |=> ((status_q & $past(status_q)) == $past(status_q))
  ) else $error("pending flag dropped without a clear");

  a_cmp_wake: assert property (
    @(posedge core_clk) disable iff (rst)
    (sleeping || idling) && cmpChange[0] && wakeEn_q[wakeup_irq_pkg::WAKE_CMP1]
    |=> wakeUp
  ) else $error("comparator change with wake enable did not wake");

  a_cmp_noie_resume: assert property (
    @(posedge core_clk) disable iff (rst)
    sleeping && cmpChange[1] && wakeEn_q[wakeup_irq_pkg::WAKE_CMP2]
    && !irqEn_q[wakeup_irq_pkg::EVT_CMP2] && (evt == cmpChange[1] << 1)
    |=> resumeNext && !vectorReq
  ) else $error("comparator wake without irq enable did not resume");

  a_cmp_both_vector: assert property (
    @(posedge core_clk) disable iff (rst)
    sleeping && cmpChange[0] && wakeEn_q[wakeup_irq_pkg::WAKE_CMP1]
    && irqEn_q[wakeup_irq_pkg::EVT_CMP1] && globalIrqEnabled
    |=> wakeUp && vectorReq && !resumeNext
  ) else $error("comparator wake with irq enable did not vector");

  a_no_wake_mask: assert property (
    @(posedge core_clk) disable iff (rst)
    (sleeping || idling) && (wakeEn_q == '0) && !timerOneEvt && !timerTwoEvt |=> !wakeUp
  ) else $error("wake without an enabled wake source");

  a_cmp_quiet: assert property (
    @(posedge core_clk) disable iff (rst)
    sleeping && (irqEn_q == '0) && (wakeEn_q == '0)
    |=> !wakeUp && !vectorReq
  ) else $error("masked source woke or vectored");

  a_timer_sleep: assert property (
    @(posedge core_clk) disable iff (rst)
    sleeping && (evt[6:2] != '0) && !cmpChange[0] && !cmpChange[1] |=> !wakeUp
  ) else $error("timer or uart woke from sleep");

  a_timer_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    idling && timerTwoEvt && irqEn_q[wakeup_irq_pkg::EVT_TMR2] |=> wakeUp
  ) else $error("timer two did not wake from idle");

  a_uart_no_wake: assert property (
    @(posedge core_clk) disable iff (rst)
    (evt[3:0] == '0) |=> !wakeUp
  ) else $error("uart event caused a wake");

  a_run_vector: assert property (
    @(posedge core_clk) disable iff (rst)
    running && globalIrqEnabled && uartRxFullEvt && irqEn_q[wakeup_irq_pkg::EVT_URX]
    |=> vectorReq && irq
  ) else $error("enabled uart event did not vector in run");

  a_gie_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    !globalIrqEnabled |=> !vectorReq
  ) else $error("vector taken with interrupts disabled");

  a_wake_outcome: assert property (
    @(posedge core_clk) disable iff (rst)
    wakeUp |-> (resumeNext != vectorReq)
  ) else $error("wake outcome not exactly one of vector or resume");

  a_cmp_wake_only: assert property (
    @(posedge core_clk) disable iff (rst)
    cmpChange[0] && !irqEn_q[wakeup_irq_pkg::EVT_CMP1] && (evt == 7'h01)
    && ((status_q & irqEn_q) == '0) |=> !vectorReq
  ) else $error("wake only comparator requested a vector");

  a_cmp_run_vector: assert property (
    @(posedge core_clk) disable iff (rst)
    running && globalIrqEnabled && cmpChange[1] && irqEn_q[wakeup_irq_pkg::EVT_CMP2]
    |=> vectorReq && !wakeUp
  ) else $error("enabled comparator did not vector in run");

  a_cmp_rest_masked: assert property (
    @(posedge core_clk) disable iff (rst)
    (sleeping || idling) && !wakeEn_q[wakeup_irq_pkg::WAKE_CMP1] && (evt == 7'h01)
    && ((status_q & irqEn_q) == '0) |=> !wakeUp && !vectorReq
  ) else $error("comparator without wake enable woke or vectored at rest");

  a_timer_one_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    idling && timerOneEvt && irqEn_q[wakeup_irq_pkg::EVT_TMR1] && globalIrqEnabled
    |=> wakeUp && vectorReq && !resumeNext
  ) else $error("timer one did not wake and vector from idle");

  a_timer_masked: assert property (
    @(posedge core_clk) disable iff (rst)
    timerTwoEvt && !irqEn_q[wakeup_irq_pkg::EVT_TMR2] && (evt == 7'h08)
    && ((status_q & irqEn_q) == '0) |=> !wakeUp && !vectorReq && !irq
  ) else $error("masked timer two had an effect");

  a_uart_tx_run: assert property (
    @(posedge core_clk) disable iff (rst)
    running && globalIrqEnabled && uartTxDoneEvt && irqEn_q[wakeup_irq_pkg::EVT_UTX]
    |=> vectorReq && !wakeUp
  ) else $error("enabled uart transmit done did not vector in run");

  a_uart_err_run: assert property (
    @(posedge core_clk) disable iff (rst)
    running && globalIrqEnabled && uartRxErrorEvt && irqEn_q[wakeup_irq_pkg::EVT_UERR]
    |=> vectorReq
  ) else $error("enabled uart receive error did not vector in run");

  a_irq_level: assert property (
    @(posedge core_clk) disable iff (rst)
    irq == ((status_q & $past(irqEn_q)) != '0)
  ) else $error("irq level does not follow enabled pending flags");

endmodule

// ===== verification/wakeup_interrupt_dispatch_test.sv
`timescale 1ns/1ps
module wakeup_interrupt_dispatch_test;
  // clock and reset
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  // register port
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  // events and core state
  logic [1:0] cmpLvl = 2'h0;
  logic [6:0] evtPulse = 7'h00;
  wakeup_irq_pkg::power_state_t powerMode = wakeup_irq_pkg::PWR_NORMAL;
  logic globalIrqEnabled = 1'b0;
  // outcome
  logic wakeUp;
  logic resumeNext;
  logic vectorReq;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 32'he41f;
  logic [31:0] rdVal;
  logic [5:0] obs;
  logic [6:0] ieBits;
  logic [1:0] weBits;
  wakeup_irq_pkg::power_state_t modes [4];

  always #25 core_clk = ~core_clk;

  wakeup_interrupt_dispatch uut (
    .core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .comparatorOut(cmpLvl),
    .timerOneEvt(evtPulse[2]), .timerTwoEvt(evtPulse[3]),
    .uartTxDoneEvt(evtPulse[4]), .uartRxFullEvt(evtPulse[5]),
    .uartRxErrorEvt(evtPulse[6]),
    .powerMode(powerMode), .globalIrqEnabled(globalIrqEnabled),
    .wakeUp(wakeUp), .resumeNext(resumeNext), .vectorReq(vectorReq), .irq(irq)
  );

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_out(input logic [5:0] got, input logic [5:0] exp, input int src);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: outcome of event %0d got %b expected %b",
               $time, src, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  // counts wake and resume pulses, so a stuck or doubled pulse shows up
  task automatic fire(input int src, output logic [5:0] o);
    logic [1:0] nWake = 2'h0;
    logic [1:0] nRes = 2'h0;
    logic vSeen = 1'b0;
    logic iSeen = 1'b0;
    @(posedge core_clk);
    if (src < 2) cmpLvl[src] <= ~cmpLvl[src];
    else evtPulse[src] <= 1'b1;
    @(posedge core_clk);
    evtPulse <= 7'h00;
    // comparator path goes through a synchroniser, hence the long window
    repeat (10) begin
      @(negedge core_clk);
      nWake = nWake + {1'b0, wakeUp};
      nRes = nRes + {1'b0, resumeNext};
      vSeen = vSeen | vectorReq;
      iSeen = iSeen | irq;
    end
    o = {nWake, nRes, vSeen, iSeen};
  endtask

  function automatic logic [5:0] expect_out(int src, int m, bit g, bit ie, bit we);
    bit rest = (m < 2);
    bit wk;
    bit vec;
    wk = (src < 2) ? (we && rest) : ((src < 4) ? (ie && m == 1) : 1'b0);
    vec = rest ? (wk && g && ie) : (g && ie);
    return {1'b0, wk, 1'b0, wk && !vec, vec, ie};
  endfunction

  initial begin
    modes[0] = wakeup_irq_pkg::PWR_SLEEP;
    modes[1] = wakeup_irq_pkg::PWR_IDLE;
    modes[2] = wakeup_irq_pkg::PWR_LOWSPEED;
    modes[3] = wakeup_irq_pkg::PWR_NORMAL;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    reg_rd(wakeup_irq_pkg::ADDR_STATUS, rdVal);
    check_reg(rdVal, 32'h0, "status after reset");
    reg_rd(wakeup_irq_pkg::ADDR_IRQ_EN, rdVal);
    check_reg(rdVal, 32'h0, "irq enable after reset");
    reg_rd(wakeup_irq_pkg::ADDR_WAKE_EN, rdVal);
    check_reg(rdVal, 32'h0, "wake enable after reset");
    reg_rd(8'h14, rdVal);
    check_reg(rdVal, 32'h0, "unmapped read");
    reg_rd(wakeup_irq_pkg::ADDR_CLEAR, rdVal);
    check_reg(rdVal, 32'h0, "clear register read");
    @(negedge core_clk);
    check_reg(regRdData, 32'h0, "read data after its cycle");
    for (int src = 0; src < 7; src++) begin
      for (int m = 0; m < 4; m++) begin
        for (int c = 0; c < 8; c++) begin
          ieBits = 7'($random(seed));
          ieBits[src] = c[0];
          weBits = 2'($random(seed));
          if (src < 2) weBits[src] = c[1];
          reg_wr(wakeup_irq_pkg::ADDR_IRQ_EN, ($random(seed) & 32'hFFFFFF80) | ieBits);
          reg_wr(wakeup_irq_pkg::ADDR_WAKE_EN, ($random(seed) & 32'hFFFFFFFC) | weBits);
          @(posedge core_clk);
          powerMode <= modes[m];
          globalIrqEnabled <= c[2];
          reg_rd(wakeup_irq_pkg::ADDR_IRQ_EN, rdVal);
          check_reg(rdVal, {25'h0, ieBits}, "irq enable readback");
          reg_rd(wakeup_irq_pkg::ADDR_WAKE_EN, rdVal);
          check_reg(rdVal, {30'h0, weBits}, "wake enable readback");
          reg_rd(wakeup_irq_pkg::ADDR_STATE, rdVal);
          check_reg(rdVal, {27'h0, c[2], modes[m]}, "state readback");
          fire(src, obs);
          check_out(obs, expect_out(src, m, c[2], c[0], c[1]), src);
          reg_rd(wakeup_irq_pkg::ADDR_STATUS, rdVal);
          check_reg(rdVal, 32'h1 << src, "pending flag");
          reg_wr(wakeup_irq_pkg::ADDR_CLEAR, 32'h7F);
          reg_rd(wakeup_irq_pkg::ADDR_STATUS, rdVal);
          check_reg(rdVal, 32'h0, "pending after clear");
          check_reg({30'h0, vectorReq, irq}, 32'h0, "irq after clear");
        end
      end
    end
    // corners: an illegal mode code acts as running
    reg_wr(wakeup_irq_pkg::ADDR_IRQ_EN, 32'h04);
    @(posedge core_clk);
    powerMode <= wakeup_irq_pkg::power_state_t'(4'h0);
    globalIrqEnabled <= 1'b1;
    fire(wakeup_irq_pkg::EVT_TMR1, obs);
    check_out(obs, expect_out(2, 2, 1'b1, 1'b1, 1'b0), 2);
    // event and clear in one cycle: the event must win
    @(posedge core_clk);
    regAddr <= wakeup_irq_pkg::ADDR_CLEAR;
    regWrData <= 32'h7F;
    regWr <= 1'b1;
    evtPulse[wakeup_irq_pkg::EVT_UERR] <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    evtPulse <= 7'h00;
    reg_rd(wakeup_irq_pkg::ADDR_STATUS, rdVal);
    check_reg(rdVal, 32'h40, "event beats clear in one cycle");
    // reset in mid-run clears pending flags, enables and outcome
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    reg_rd(wakeup_irq_pkg::ADDR_IRQ_EN, rdVal);
    check_reg(rdVal, 32'h0, "irq enable after second reset");
    reg_rd(wakeup_irq_pkg::ADDR_STATUS, rdVal);
    check_reg(rdVal, 32'h0, "status after second reset");
    check_reg({28'h0, wakeUp, resumeNext, vectorReq, irq}, 32'h0, "outputs after reset");
    end_of_test;
  end

  initial begin
    #1_000_000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule
